// File: design/cmpl_top.v
// six comparator channels behind an AXI4-Lite register slave
// assumes analog outputs and timer clocks are asynchronous to clk
`timescale 1ns/100ps
`include "cmpl_map.vh"

module cmpl_top (
  // clock and reset
  input wire clk,
  input wire nrst,
  // write address channel
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // analog comparator cores
  input wire [5:0] cmp_raw,
  output reg [5:0] cmp_on,
  output reg [5:0] input_separation_enable,
  output reg [5:0] speed_power_select,
  // gate timer side
  input wire tmr_src_clk,
  input wire tmr_pre_clk,
  input wire tmr_pre_sel,
  output wire [5:0] cmp_gate_out,
  // flags toward the interrupt controller
  output reg [5:0] cmp_irq_flag
);

  reg [5:0] output_invert;
  reg [5:0] glitch_hold_filter_enable;
  reg [5:0] sync_enable;
  reg [5:0] rise_edge_irq_enable;
  reg [5:0] fall_edge_irq_enable;
  wire [5:0] channel_result;
  wire [5:0] edge_evt;
  localparam [7:0] A_RST = `CMPL_A_RESET;
  localparam [7:0] E_RST = `CMPL_E_RESET;

  // write channel holding
  reg aw_held;
  reg w_held;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  reg wr_lane0;
  wire wr_go;
  wire [2:0] wr_idx;
  reg wr_ctrl;
  reg wr_edge;
  reg wr_flag;
  reg wr_ok;

  // read decode
  wire [2:0] rd_idx;
  reg [7:0] rd_val;
  reg rd_ok;

  // timer clock synchronisers
  reg src_s1;
  reg src_s2;
  reg pre_s1;
  reg pre_s2;
  reg sel_s1;
  reg sel_s2;
  reg tclk_last;
  wire tclk;
  wire tmr_fall;

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = wr_addr[4:2];
  assign rd_idx = s_axi_araddr[4:2];

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMPL_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CMPL_RESP_OKAY : `CMPL_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // write decode
  always @*
  begin
    wr_ctrl = 1'b0;
    wr_edge = 1'b0;
    wr_flag = 1'b0;
    wr_ok = 1'b1;
    if (wr_addr[1:0] != 2'h0)
      wr_ok = 1'b0;
    else if (wr_addr[7:5] == `CMPL_CTRL_A_BASE >> 5 &&
             wr_idx < `CMPL_NCHAN)
      wr_ctrl = 1'b1;
    else if (wr_addr[7:5] == `CMPL_EDGE_BASE >> 5 &&
             wr_idx < `CMPL_NCHAN)
      wr_edge = 1'b1;
    else if (wr_addr == `CMPL_FLAG_ADDR)
      wr_flag = 1'b1;
    else if (wr_addr == `CMPL_MIRROR_ADDR)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  // per-channel registers and datapath
  genvar i;
  generate
    for (i = 0; i < `CMPL_NCHAN; i = i + 1)
    begin : g_chan
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          cmp_on[i] <= A_RST[`CMPL_A_ON];
          output_invert[i] <= A_RST[`CMPL_A_INVERT];
          glitch_hold_filter_enable[i] <= A_RST[`CMPL_A_FILTER];
          speed_power_select[i] <= A_RST[`CMPL_A_SPEED];
          input_separation_enable[i] <= A_RST[`CMPL_A_HYST];
          sync_enable[i] <= A_RST[`CMPL_A_SYNC];
        end
        else if (wr_go && wr_lane0 && wr_ctrl && wr_idx == i)
        begin
          cmp_on[i] <= wr_data[`CMPL_A_ON];
          output_invert[i] <= wr_data[`CMPL_A_INVERT];
          glitch_hold_filter_enable[i] <= wr_data[`CMPL_A_FILTER];
          speed_power_select[i] <= wr_data[`CMPL_A_SPEED];
          input_separation_enable[i] <= wr_data[`CMPL_A_HYST];
          sync_enable[i] <= wr_data[`CMPL_A_SYNC];
        end
      end

      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          rise_edge_irq_enable[i] <= E_RST[`CMPL_E_RISE];
          fall_edge_irq_enable[i] <= E_RST[`CMPL_E_FALL];
        end
        else if (wr_go && wr_lane0 && wr_edge && wr_idx == i)
        begin
          rise_edge_irq_enable[i] <= wr_data[`CMPL_E_RISE];
          fall_edge_irq_enable[i] <= wr_data[`CMPL_E_FALL];
        end
      end

      // an edge in the clearing cycle keeps the flag set
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          cmp_irq_flag[i] <= 1'b0;
        else if (edge_evt[i])
          cmp_irq_flag[i] <= 1'b1;
        else if (wr_go && wr_lane0 && wr_flag && wr_data[i])
          cmp_irq_flag[i] <= 1'b0;
      end

      cmpl_chan u_chan (
        .clk(clk),
        .nrst(nrst),
        .raw_in(cmp_raw[i]),
        .on(cmp_on[i]),
        .invert(output_invert[i]),
        .filt_en(glitch_hold_filter_enable[i]),
        .sync_en(sync_enable[i]),
        .rise_en(rise_edge_irq_enable[i]),
        .fall_en(fall_edge_irq_enable[i]),
        .tmr_fall(tmr_fall),
        .result(channel_result[i]),
        .gate_out(cmp_gate_out[i]),
        .edge_evt(edge_evt[i])
      );
    end
  endgenerate

  // timer clock: pick prescaled or raw, then find falling edges
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      src_s1 <= 1'b0;
      src_s2 <= 1'b0;
      pre_s1 <= 1'b0;
      pre_s2 <= 1'b0;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      tclk_last <= 1'b0;
    end
    else
    begin
      src_s1 <= tmr_src_clk;
      src_s2 <= src_s1;
      pre_s1 <= tmr_pre_clk;
      pre_s2 <= pre_s1;
      sel_s1 <= tmr_pre_sel;
      sel_s2 <= sel_s1;
      tclk_last <= tclk;
    end
  end

  assign tclk = sel_s2 ? pre_s2 : src_s2;
  assign tmr_fall = tclk_last & ~tclk;

  // read decode
  always @*
  begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    if (s_axi_araddr[1:0] != 2'h0)
      rd_ok = 1'b0;
    else if (s_axi_araddr[7:5] == `CMPL_CTRL_A_BASE >> 5 &&
             rd_idx < `CMPL_NCHAN)
    begin
      rd_val[`CMPL_A_ON] = cmp_on[rd_idx];
      rd_val[`CMPL_A_RESULT] = channel_result[rd_idx];
      rd_val[`CMPL_A_INVERT] = output_invert[rd_idx];
      rd_val[`CMPL_A_FILTER] = glitch_hold_filter_enable[rd_idx];
      rd_val[`CMPL_A_SPEED] = speed_power_select[rd_idx];
      rd_val[`CMPL_A_HYST] = input_separation_enable[rd_idx];
      rd_val[`CMPL_A_SYNC] = sync_enable[rd_idx];
    end
    else if (s_axi_araddr[7:5] == `CMPL_EDGE_BASE >> 5 &&
             rd_idx < `CMPL_NCHAN)
    begin
      rd_val[`CMPL_E_RISE] = rise_edge_irq_enable[rd_idx];
      rd_val[`CMPL_E_FALL] = fall_edge_irq_enable[rd_idx];
    end
    else if (s_axi_araddr == `CMPL_FLAG_ADDR)
      rd_val = {2'h0, cmp_irq_flag};
    else if (s_axi_araddr == `CMPL_MIRROR_ADDR)
      rd_val = {2'h0, channel_result};
    else
      rd_ok = 1'b0;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMPL_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_ok ? `CMPL_RESP_OKAY : `CMPL_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// File: design/cmpl_map.vh
// register map, field positions, reset values and timing counts
// assumes a 40 MHz system clock
`ifndef CMPL_MAP_VH
`define CMPL_MAP_VH

// byte addresses
`define CMPL_CTRL_A_BASE 8'h00
`define CMPL_EDGE_BASE 8'h20
`define CMPL_FLAG_ADDR 8'h40
`define CMPL_MIRROR_ADDR 8'h44
`define CMPL_NCHAN 6

// comparator_control_a fields
`define CMPL_A_ON 7
`define CMPL_A_RESULT 6
`define CMPL_A_INVERT 4
`define CMPL_A_FILTER 3
`define CMPL_A_SPEED 2
`define CMPL_A_HYST 1
`define CMPL_A_SYNC 0

// comparator_edge_control fields
`define CMPL_E_RISE 1
`define CMPL_E_FALL 0

// reset values
`define CMPL_A_RESET 8'h04
`define CMPL_E_RESET 8'h00

// glitch hold time and its count of clock cycles
`define CMPL_CLK_NS 25
`define CMPL_FILT_NS 20
`define CMPL_FILT_CYC (((`CMPL_FILT_NS / `CMPL_CLK_NS) < 1) ? 1 : \
  (`CMPL_FILT_NS / `CMPL_CLK_NS))

// answers on the register bus
`define CMPL_RESP_OKAY 2'h0
`define CMPL_RESP_SLVERR 2'h2

`endif

// File: design/cmpl_chan.v
// one comparator channel: polarity, glitch hold filter, timer-aligned
// latch and edge detection; assumes raw_in is asynchronous to clk and
// tmr_fall is a one-cycle pulse already in the clk domain
`timescale 1ns/100ps
`include "cmpl_map.vh"

module cmpl_chan (
  // clock and reset
  input wire clk,
  input wire nrst,
  // analog core
  input wire raw_in,
  // controls
  input wire on,
  input wire invert,
  input wire filt_en,
  input wire sync_en,
  input wire rise_en,
  input wire fall_en,
  input wire tmr_fall,
  // results
  output reg result,
  output wire gate_out,
  output wire edge_evt
);

  localparam integer HOLD_INT = `CMPL_FILT_CYC;
  localparam [3:0] HOLD_CYC = HOLD_INT[3:0];

  reg raw_s1;
  reg raw_s2;
  reg prev;
  reg aligned;
  reg [3:0] hold;
  wire cand;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      raw_s1 <= 1'b0;
      raw_s2 <= 1'b0;
    end
    else
    begin
      raw_s1 <= raw_in;
      raw_s2 <= raw_s1;
    end
  end

  // a disabled core reads low, so toggling invert still moves it
  assign cand = (on & raw_s2) ^ invert;

  // result sampled once per clock; reversal blocked while hold runs
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      result <= 1'b0;
      hold <= 4'h0;
    end
    else if (filt_en && hold != 4'h0)
    begin
      hold <= hold - 4'h1;
    end
    else
    begin
      result <= cand;
      if (cand != result)
        hold <= HOLD_CYC;
      else
        hold <= 4'h0;
    end
  end

  // edges of the post-polarity result
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev <= 1'b0;
    else
      prev <= result;
  end

  assign edge_evt = (rise_en & result & ~prev) |
                    (fall_en & ~result & prev);

  // timer-aligned copy changes only at timer clock falls
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      aligned <= 1'b0;
    else if (tmr_fall)
      aligned <= result;
  end

  // unaligned path follows the core with no clocked stage
  assign gate_out = sync_en ? aligned : ((on & raw_in) ^ invert);
endmodule

// File: tb/cmpl_far_model.sv
// far side: analog comparator cores and the gate timer clocks
// assumes the bench sets input levels and starts each timer clock
`timescale 1ns/100ps
module cmpl_far (
  // bench controls, lvl high = plus input above minus input
  input wire [5:0] lvl,
  input wire [5:0] on,
  input wire src_run,
  input wire pre_run,
  // toward the block
  output wire [5:0] raw,
  output reg tsrc,
  output reg tpre
);
  // a disabled core is powered down and reads low
  assign raw = lvl & on;
  initial tsrc = 1'h0;
  initial tpre = 1'h0;
  always #97 tsrc = src_run ? ~tsrc : 1'h0;
  always #211 tpre = pre_run ? ~tpre : 1'h0;
endmodule

// File: tb/cmpl_top_properties.sv
// register bus and flag checks on the ports of cmpl_top
// assumes one clock domain, bound below
`timescale 1ns/100ps
module cmpl_chk (
  // watched ports
  input wire clk,
  input wire nrst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_bready,
  input wire s_axi_rready,
  input wire [5:0] speed_power_select,
  input wire [5:0] cmp_irq_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  a_ar_ready: assert property (s_axi_arready != s_axi_rvalid)
    else $error("arready wrong");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read answer");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("no write answer");
  a_slot_busy: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("slot open early");
  a_rd_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper rdata set");
  a_spd_reset: assert property ($rose(nrst) |->
    speed_power_select == 6'h3F) else $error("speed reset");
  a_flag_clear: assert property (|($past(cmp_irq_flag) & ~cmp_irq_flag)
    |-> $rose(s_axi_bvalid)) else $error("flag fell alone");
endmodule
bind cmpl_top cmpl_chk u_chk (.clk, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_bready, .s_axi_rready, .speed_power_select,
  .cmp_irq_flag);

// File: tb/cmpl_top_test.sv
// self-checking bench for cmpl_top through its register bus
// assumes cmpl_far stands in for the cores and the timer clocks
`timescale 1ns/100ps
module cmpl_top_test;
  reg clk = 1'h0;
  reg nrst = 1'h0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [7:0] s_axi_araddr = 8'h00;
  reg s_axi_awvalid = 1'h0;
  reg s_axi_wvalid = 1'h0;
  reg s_axi_arvalid = 1'h0;
  reg tmr_pre_sel = 1'h0;
  reg src_run = 1'h0;
  reg pre_run = 1'h0;
  reg [5:0] lvl = 6'h00;
  reg [7:0] rdv;
  reg [1:0] rsp, bsp;
  reg ka, kw;
  integer err_total = 0;
  integer tests_run = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, tmr_src_clk, tmr_pre_clk;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [5:0] cmp_raw, cmp_on, input_separation_enable;
  wire [5:0] speed_power_select, cmp_gate_out, cmp_irq_flag;
  reg [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_bready = 1'h1;
  wire s_axi_rready = 1'h1;
  always #12.5 clk = ~clk;
  cmpl_top u_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw, .cmp_on,
    .input_separation_enable, .speed_power_select, .tmr_src_clk,
    .tmr_pre_clk, .tmr_pre_sel, .cmp_gate_out, .cmp_irq_flag);
  cmpl_far u_far (.lvl(lvl), .on(cmp_on), .src_run(src_run),
    .pre_run(pre_run), .raw(cmp_raw), .tsrc(tmr_src_clk),
    .tpre(tmr_pre_clk));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      ka = 1'h0;
      kw = 1'h0;
      while (!(ka && kw && s_axi_bvalid))
      begin
        @(posedge clk);
        if (s_axi_awready)
          ka = 1'h1;
        if (s_axi_wready)
          kw = 1'h1;
        if (ka)
          s_axi_awvalid <= 1'h0;
        if (kw)
          s_axi_wvalid <= 1'h0;
      end
      bsp = s_axi_bresp;
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      @(posedge clk);
      while (!s_axi_arready)
        @(posedge clk);
      s_axi_arvalid <= 1'h0;
      @(posedge clk);
      while (!s_axi_rvalid)
        @(posedge clk);
      rdv = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      rd(a);
      chk("rdata", e, rdv);
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial
  begin
    #300000;
    err_total = err_total + 1;
    results;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    chk("speed", 8'h3F, {2'h0, speed_power_select});
    rc(8'h00, 8'h04);
    rc(8'h20, 8'h00);
    wr(8'h00, 8'h86);
    chk("on", 8'h01, {2'h0, cmp_on});
    chk("hyst", 8'h01, {2'h0, input_separation_enable});
    chk("speed", 8'h3F, {2'h0, speed_power_select});
    wr(8'h00, 8'h04);
    chk("on", 8'h00, {2'h0, cmp_on});
    s_axi_wstrb <= 4'hE;
    wr(8'h00, 8'h86);
    chk("bresp", 8'h00, {6'h0, bsp});
    chk("on", 8'h00, {2'h0, cmp_on});
    s_axi_wstrb <= 4'hF;
    wr(8'h80, 8'hFF);
    chk("bresp", 8'h02, {6'h0, bsp});
    rd(8'h80);
    chk("rresp", 8'h02, {6'h0, rsp});
    wr(8'h04, 8'h84);
    lvl <= 6'h02;
    repeat (6) @(posedge clk);
    rc(8'h04, 8'hC4);
    rc(8'h44, 8'h02);
    chk("gate", 8'h02, {2'h0, cmp_gate_out});
    wr(8'h04, 8'h94);
    repeat (6) @(posedge clk);
    rc(8'h04, 8'h94);
    chk("gate", 8'h00, {2'h0, cmp_gate_out});
    wr(8'h28, 8'h02);
    wr(8'h08, 8'h84);
    lvl <= 6'h06;
    repeat (6) @(posedge clk);
    rc(8'h40, 8'h04);
    wr(8'h40, 8'h04);
    rc(8'h40, 8'h00);
    lvl <= 6'h02;
    repeat (6) @(posedge clk);
    rc(8'h40, 8'h00);
    wr(8'h28, 8'h01);
    lvl <= 6'h06;
    repeat (6) @(posedge clk);
    rc(8'h40, 8'h00);
    lvl <= 6'h02;
    repeat (6) @(posedge clk);
    rc(8'h40, 8'h04);
    wr(8'h40, 8'h04);
    wr(8'h2C, 8'h03);
    wr(8'h0C, 8'h14);
    repeat (6) @(posedge clk);
    rc(8'h40, 8'h08);
    wr(8'h10, 8'h8D);
    lvl <= 6'h12;
    repeat (40) @(posedge clk);
    chk("gate4", 8'h00, {7'h0, cmp_gate_out[4]});
    src_run <= 1'h1;
    repeat (40) @(posedge clk);
    chk("gate4", 8'h01, {7'h0, cmp_gate_out[4]});
    tmr_pre_sel <= 1'h1;
    lvl <= 6'h02;
    repeat (40) @(posedge clk);
    chk("gate4", 8'h01, {7'h0, cmp_gate_out[4]});
    pre_run <= 1'h1;
    repeat (60) @(posedge clk);
    chk("gate4", 8'h00, {7'h0, cmp_gate_out[4]});
    results;
  end
endmodule
